// ### rtl/spss_sequencer.sv
// Function
// - Device initializes into soft standby, 1 ms
// - Streaming only after PLL lock, 1 ms
// - Device may hold control data low
// - Stop streaming at row or frame end
// - Shutdown low: hard standby, registers default
// - Single-pin or two-pin control mode
`timescale 1ns/10ps
module spss_sequencer
    import spss_pkg::*;
#(
    parameter int unsigned INIT_COUNT = INIT_CYCLES,
    parameter int unsigned LOCK_COUNT = LOCK_CYCLES,
    parameter int unsigned CNT_WIDTH  = 16
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_two_pin_mode,
    input  wire logic i_power_enable_pin,
    input  wire logic i_reset_release_pin,
    input  wire logic i_analog_supply,
    input  wire logic i_pixel_array_supply,
    input  wire logic i_reference_clock_input,
    input  wire logic i_stream_select,
    input  wire logic i_stop_on_row,
    input  wire logic i_row_end,
    input  wire logic i_frame_end,
    input  wire logic i_serial_control_data_line,
    output logic      o_serial_control_data_line,
    output logic      o_serial_control_data_line_oe,
    output logic      o_hard_standby,
    output logic      o_soft_standby,
    output logic      o_streaming,
    output logic      o_pll_locked,
    output logic      o_register_reset
);
    // Timer needs two bits at least for its end-of-count compare
    initial begin
        if (CNT_WIDTH < 2 || CNT_WIDTH > 31)
            $error("spss_sequencer: CNT_WIDTH must lie between 2 and 31");
        if (INIT_COUNT < 1)
            $error("spss_sequencer: INIT_COUNT must be nonzero");
        if (LOCK_COUNT < 1)
            $error("spss_sequencer: LOCK_COUNT must be nonzero");
        if (INIT_COUNT >= (1 << CNT_WIDTH))
            $error("spss_sequencer: INIT_COUNT does not fit CNT_WIDTH");
        if (LOCK_COUNT >= (1 << CNT_WIDTH))
            $error("spss_sequencer: LOCK_COUNT does not fit CNT_WIDTH");
    end

    spss_state_type state;
    spss_state_type next_state;

    // Single-pin mode: shutdown pin also releases reset
    wire power_up      = i_two_pin_mode ? (i_power_enable_pin && i_reset_release_pin)
                                        : i_power_enable_pin;
    wire analog_ready  = i_analog_supply && i_pixel_array_supply && i_reference_clock_input;
    wire stop_boundary = i_stop_on_row ? i_row_end : i_frame_end;
    wire enter_state   = (next_state != state);
    wire start_timer   = enter_state &&
                         (next_state == SPSS_INIT || next_state == SPSS_PLL_LOCK);
    wire [CNT_WIDTH-1:0] timer_count = (next_state == SPSS_INIT) ?
                                       CNT_WIDTH'(INIT_COUNT) : CNT_WIDTH'(LOCK_COUNT);
    logic timer_done;
    logic init_armed;
    wire  init_finished = timer_done && init_armed;

    spss_timer #(
        .WIDTH (CNT_WIDTH)
    ) u_timer (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_start (start_timer),
        .i_count (timer_count),
        .o_done  (timer_done)
    );

    always_comb begin
        next_state = state;
        unique case (state)
            SPSS_HARD_STANDBY: begin
                // Wait for supplies and clock, not just pin release
                if (power_up && analog_ready)
                    next_state = SPSS_INIT;
            end
            SPSS_INIT: begin
                if (init_finished)
                    next_state = SPSS_SOFT_STANDBY;
            end
            SPSS_SOFT_STANDBY: begin
                if (i_stream_select)
                    next_state = SPSS_PLL_LOCK;
            end
            SPSS_PLL_LOCK: begin
                if (!i_stream_select)
                    next_state = SPSS_SOFT_STANDBY;
                else if (timer_done)
                    next_state = SPSS_STREAMING;
            end
            SPSS_STREAMING: begin
                if (!i_stream_select)
                    next_state = SPSS_STOPPING;
            end
            SPSS_STOPPING: begin
                if (stop_boundary)
                    next_state = SPSS_SOFT_STANDBY;
            end
            default: next_state = SPSS_HARD_STANDBY;
        endcase
        // Pin low overrides everything, from any state
        if (!power_up)
            next_state = SPSS_HARD_STANDBY;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state      <= SPSS_HARD_STANDBY;
            init_armed <= 1'b0;
        end else begin
            state      <= next_state;
            // Guards against a stale done from an aborted lock wait
            init_armed <= (next_state == SPSS_INIT) && !(start_timer);
        end
    end

    // Flops load from next state, so outputs move on the edge that moves the state
    wire next_is_hard    = (next_state == SPSS_HARD_STANDBY);
    wire next_is_soft    = (next_state == SPSS_SOFT_STANDBY);
    wire next_is_output  = (next_state == SPSS_STREAMING) || (next_state == SPSS_STOPPING);
    wire next_holds_line = next_is_hard && power_up;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_hard_standby <= 1'b1;
            o_soft_standby <= 1'b0;
        end else begin
            o_hard_standby <= next_is_hard;
            o_soft_standby <= next_is_soft;
        end
    end

    // Output keeps running through the stop wait, lock flagged with it
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_streaming  <= 1'b0;
            o_pll_locked <= 1'b0;
        end else begin
            o_streaming  <= next_is_output;
            o_pll_locked <= next_is_output;
        end
    end

    // Registers return to defaults while in hard standby
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_register_reset <= 1'b1;
        end else begin
            o_register_reset <= next_is_hard;
        end
    end

    // Pulls the data line low from pin release until supplies and clock end hard standby
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_serial_control_data_line_oe <= 1'b0;
        end else begin
            o_serial_control_data_line_oe <= next_holds_line;
        end
    end
    assign o_serial_control_data_line = 1'b0;
endmodule // spss_sequencer

// ### rtl/spss_pkg.sv
package spss_pkg;
    localparam int unsigned CLK_HZ            = 40000000;
    // Internal initialization into soft standby, least time
    localparam int unsigned INIT_TIME_US      = 1000;
    // PLL lock after streaming request, least time
    localparam int unsigned LOCK_TIME_US      = 1000;
    localparam int unsigned INIT_CYCLES       = (INIT_TIME_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned LOCK_CYCLES       = (LOCK_TIME_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam logic [15:0] STREAM_SELECT_OFS = 16'h0100;
    localparam logic        STOP_ON_ROW       = 1'b1;

    typedef enum logic [5:0] {
        SPSS_HARD_STANDBY = 6'h01,
        SPSS_INIT         = 6'h02,
        SPSS_SOFT_STANDBY = 6'h04,
        SPSS_PLL_LOCK     = 6'h08,
        SPSS_STREAMING    = 6'h10,
        SPSS_STOPPING     = 6'h20
    } spss_state_type;
endpackage

// ### rtl/spss_timer.sv
`timescale 1ns/10ps
module spss_timer #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_start,
    input  wire logic [WIDTH-1:0] i_count,
    output logic                  o_done
);
    logic [WIDTH-1:0] remaining;
    logic             running;
    wire              at_end = running && (remaining == {{(WIDTH-1){1'b0}}, 1'b1});

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            remaining <= '0;
            running   <= 1'b0;
            o_done    <= 1'b0;
        end else begin
            // A restart on the last count must not leak a done into the new wait
            o_done <= at_end && !i_start;
            if (i_start) begin
                remaining <= i_count;
                running   <= 1'b1;
            end else if (running) begin
                remaining <= remaining - {{(WIDTH-1){1'b0}}, 1'b1};
                running   <= !at_end;
            end
        end
    end
endmodule // spss_timer

// ### verification/spss_sequencer_sva.sv
`timescale 1ns/10ps
module spss_sequencer_sva (
    input wire logic i_clk, i_rst, i_two_pin_mode, i_power_enable_pin, i_reset_release_pin,
    input wire logic i_stream_select, i_stop_on_row, i_row_end, i_frame_end,
    input wire logic o_serial_control_data_line, o_serial_control_data_line_oe,
    input wire logic o_hard_standby, o_soft_standby, o_streaming, o_pll_locked, o_register_reset
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_hard; !i_power_enable_pin |=> o_hard_standby && o_register_reset; endproperty
    a_hard: assert property (p_hard) else $error("pin low, no hard standby");
    property p_two; i_two_pin_mode && !i_reset_release_pin |=> o_hard_standby; endproperty
    a_two: assert property (p_two) else $error("reset pin ignored");
    // Six cycles leave room for the two-cycle slack on a count of eight
    property p_init; $fell(o_hard_standby) |-> !o_soft_standby [*6] ##[1:20]
        (o_soft_standby || o_hard_standby); endproperty
    a_init: assert property (p_init) else $error("init time wrong");
    property p_lock; $fell(o_soft_standby) && !o_hard_standby |-> !o_streaming [*6]; endproperty
    a_lock: assert property (p_lock) else $error("streaming before lock");
    property p_flag; o_streaming |-> o_pll_locked; endproperty
    a_flag: assert property (p_flag) else $error("streaming unlocked");
    property p_start; $rose(o_streaming) |-> $past(i_stream_select); endproperty
    a_start: assert property (p_start) else $error("unrequested streaming");
    property p_stop; $fell(o_streaming) && !o_hard_standby |->
        ($past(i_stop_on_row) ? $past(i_row_end) : $past(i_frame_end)); endproperty
    a_stop: assert property (p_stop) else $error("stop off boundary");
    property p_sda; o_serial_control_data_line_oe |-> o_hard_standby
        && !o_serial_control_data_line; endproperty
    a_sda: assert property (p_sda) else $error("data line pulled outside power-up");
endmodule // spss_sequencer_sva
bind spss_sequencer spss_sequencer_sva i_spss_sequencer_sva (.*);

// ### verification/spss_host.sv
`timescale 1ns/10ps
module spss_host (
    input  wire logic i_clk,
    input  wire logic i_up,
    input  wire logic i_two,
    output logic      o_pwr,
    output logic      o_rel,
    output logic      o_ana,
    output logic      o_clk
);
    logic [3:0] step;
    // All pins drop together on power-down, which the supply steps allow
    always_ff @(posedge i_clk) step <= !i_up ? 4'h0 : step + 4'(step != 4'hF);
    assign o_clk = step > 4'h1;
    assign o_ana = i_two ? step > 4'h1 : step > 4'h7;
    assign o_pwr = i_two ? step > 4'h4 : step > 4'h3;
    // Ignored pin in single-pin mode toggles until the steps saturate, then holds high
    assign o_rel = i_two ? step > 4'h7 : step[0];
endmodule // spss_host

// ### verification/test_spss_sequencer.sv
`timescale 1ns/10ps
module test_spss_sequencer;
    localparam int N = 8;
    logic i_clk = 0, i_rst = 1, up = 0, i_two_pin_mode = 0, i_stream_select = 0;
    logic i_stop_on_row = 0, i_row_end = 0, i_frame_end = 0;
    wire  i_power_enable_pin, i_reset_release_pin, i_analog_supply, i_reference_clock_input;
    wire  i_pixel_array_supply = i_analog_supply;
    logic o_serial_control_data_line, o_serial_control_data_line_oe, o_hard_standby;
    logic o_soft_standby, o_streaming, o_pll_locked, o_register_reset;
    // Pull-up on the data line, device only pulls low
    wire  i_serial_control_data_line = o_serial_control_data_line_oe ?
                                       o_serial_control_data_line : 1'b1;
    int   seed = 32'hdd358e1a, miscompares = 0, check_count = 0, n;
    always #12.5 i_clk = !i_clk;
    spss_host i_spss_host (.i_clk(i_clk), .i_up(up), .i_two(i_two_pin_mode),
        .o_pwr(i_power_enable_pin), .o_rel(i_reset_release_pin), .o_ana(i_analog_supply),
        .o_clk(i_reference_clock_input));
    spss_sequencer #(.INIT_COUNT(N), .LOCK_COUNT(N)) i_spss_sequencer (.*);
    function automatic logic at_edge(logic r, logic f, logic s);
        return s ? r : f;
    endfunction
    task summarize;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp, input string m);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic wt(ref logic s, output int c);
        c = 0;
        while (s !== 1'b1 && c < 60) begin
            @(negedge i_clk);
            c++;
        end
        if (c >= 60) begin
            miscompares++;
            summarize();
        end
    endtask
    task automatic pulse(input logic r);
        @(posedge i_clk);
        i_row_end <= r;
        i_frame_end <= !r;
        @(posedge i_clk);
        i_row_end <= 0;
        i_frame_end <= 0;
        repeat (2) @(negedge i_clk);
        chk(o_streaming, !at_edge(r, !r, i_stop_on_row), "stop at boundary");
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 0;
        for (int k = 0; k < 6; k++) begin
            @(posedge i_clk);
            i_two_pin_mode <= k[0];
            i_stop_on_row <= 1'($random(seed));
            up <= 1;
            // Single-pin host raises the pin before supplies, so the line is held
            repeat (7) @(negedge i_clk);
            chk(i_serial_control_data_line, i_two_pin_mode, "data line hold");
            wt(o_soft_standby, n);
            chk(n > N, 1'b1, "init too short");
            chk(o_register_reset, 1'b0, "registers held");
            @(posedge i_clk) i_stream_select <= 1;
            wt(o_streaming, n);
            chk(n > N - 3, 1'b1, "lock too short");
            chk(o_pll_locked, 1'b1, "lock flag");
            @(posedge i_clk) i_stream_select <= 0;
            pulse(!i_stop_on_row);
            pulse(i_stop_on_row);
            chk(o_soft_standby, 1'b1, "no soft standby");
            repeat (($random(seed) & 7) + 2) @(posedge i_clk);
            up <= 0;
            repeat (3) @(negedge i_clk);
            chk(o_hard_standby && o_register_reset, 1'b1, "hard standby");
        end
        summarize();
    end
endmodule // test_spss_sequencer
